// file: emr_pkg.sv
// Package with constants and types for the emergency message reporter.
//==========================================================================
//==========================================================================
package emr_pkg;
   localparam logic [15:0] EMR_FLAGS_INDEX   = 16'h10F3;
   localparam logic [7:0]  EMR_FLAGS_SUB     = 8'h05;
   localparam logic [15:0] EMR_FLAGS_RESET   = 16'h003F;
   localparam int          EMR_EN_BIT        = 0;
   localparam int          EMR_HIST_BIT      = 5;
   localparam int          EMR_QUEUE_DEPTH   = 8;
   localparam int          EMR_PAYLOAD_BYTES = 8;
   localparam logic [2:0]  EMR_LAST_BYTE     = 3'h7;

   typedef enum logic [1:0]
   {
      EMR_INIT,
      EMR_PREOP,
      EMR_SAFEOP,
      EMR_OP
   } emr_state_t;

   typedef struct packed
   {
      logic [39:0] vendor;
      logic [7:0]  err_reg;
      logic [15:0] err_code;
   } emr_msg_t;
endpackage : emr_pkg

// file: emr_reporter.sv
// Emergency message reporter: queue, enable flag and byte serialiser.
module emr_reporter
(
   // Clock and reset.
   input  wire logic               i_clock,
   input  wire logic               i_sys_rst,
   // Drive status.
   input  wire logic               i_alarm,
   input  wire logic               i_warning,
   input  wire logic [15:0]        i_err_code,
   input  wire logic [7:0]         i_err_reg,
   input  wire logic [39:0]        i_vendor,
   input  wire logic               i_hist_clear_done,
   input  wire emr_pkg::emr_state_t i_esm_state,
   // Flags word access.
   input  wire logic               i_flags_wr,
   input  wire logic [15:0]        i_flags_wdata,
   output logic [15:0]             o_flags,
   // Mailbox byte stream.
   output logic                    o_mbx_valid,
   output logic [7:0]              o_mbx_data,
   output logic                    o_mbx_last,
   input  wire logic               i_mbx_ready
);

   //=======================================================================
   // Alarm edge detection and flags.
   logic                  alarm_r, alarm_nxt;
   logic                  en_r, en_nxt;
   logic                  hist_r, hist_nxt;
   logic                  new_alarm;
   emr_pkg::emr_msg_t     msg;

   assign new_alarm = i_alarm & ~alarm_r;
   assign msg.err_code = i_err_code;
   assign msg.err_reg  = i_err_reg;
   assign msg.vendor   = i_vendor;

   always_comb
   begin
      alarm_nxt = i_alarm;
      en_nxt    = i_flags_wr ? i_flags_wdata[emr_pkg::EMR_EN_BIT] : en_r;
      hist_nxt  = hist_r;
      if (i_hist_clear_done)
      begin
         hist_nxt = 1'b1;
      end
      if (new_alarm)
      begin
         hist_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         alarm_r <= 1'b0;
         en_r    <= emr_pkg::EMR_FLAGS_RESET[emr_pkg::EMR_EN_BIT];
         hist_r  <= emr_pkg::EMR_FLAGS_RESET[emr_pkg::EMR_HIST_BIT];
      end
      else
      begin
         alarm_r <= alarm_nxt;
         en_r    <= en_nxt;
         hist_r  <= hist_nxt;
      end
   end

   //=======================================================================
   // Flags word assembly.
   logic [15:0]           flags_word;

   // Bits 6 to 15 are reserved and read zero.
   always_comb
   begin
      flags_word                        = 16'h0000;
      flags_word[emr_pkg::EMR_EN_BIT]   = en_r;
      flags_word[4:1]                   = 4'hF;
      flags_word[emr_pkg::EMR_HIST_BIT] = hist_r;
   end

   assign o_flags = flags_word;

   //=======================================================================
   // Ordered message queue.
   emr_pkg::emr_msg_t     q_r   [emr_pkg::EMR_QUEUE_DEPTH];
   emr_pkg::emr_msg_t     q_nxt [emr_pkg::EMR_QUEUE_DEPTH];
   logic [3:0]            cnt_r;
   logic [3:0]            cnt_nxt;
   logic [3:0]            wr_idx;
   logic                  q_full;
   logic                  q_empty;
   logic                  in_init;
   logic                  push;
   logic                  pop;
   logic                  busy_r;
   logic                  busy_nxt;
   logic [2:0]            byte_r;
   logic [2:0]            byte_nxt;

   assign q_full  = (cnt_r == 4'(emr_pkg::EMR_QUEUE_DEPTH));
   assign q_empty = (cnt_r == 4'h0);
   assign in_init = (i_esm_state == emr_pkg::EMR_INIT);
   // Pushes on a full queue are dropped.
   assign push    = new_alarm & en_r & ~q_full;
   assign pop     = ~busy_r & ~q_empty & ~in_init;
   assign wr_idx  = pop ? (cnt_r - 4'h1) : cnt_r;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (push && !pop)
      begin
         cnt_nxt = cnt_r + 4'h1;
      end
      else if (pop && !push)
      begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   // Each entry shifts down on pop and takes the new message at wr_idx.
   generate
      for (genvar g = 0; g < emr_pkg::EMR_QUEUE_DEPTH; g++)
      begin : g_entry
         emr_pkg::emr_msg_t     above;
         if (g < emr_pkg::EMR_QUEUE_DEPTH - 1)
         begin : g_mid
            assign above = q_r[g + 1];
         end
         else
         begin : g_top
            assign above = '0;
         end
         always_comb
         begin
            q_nxt[g] = q_r[g];
            if (pop)
            begin
               q_nxt[g] = above;
            end
            if (push && (wr_idx == 4'(g)))
            begin
               q_nxt[g] = msg;
            end
         end
         always_ff @(posedge i_clock or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               q_r[g] <= '0;
            end
            else
            begin
               q_r[g] <= q_nxt[g];
            end
         end
      end
   endgenerate

   //=======================================================================
   // Byte serialiser.
   emr_pkg::emr_msg_t     cur_r;
   emr_pkg::emr_msg_t     cur_nxt;
   logic [7:0]            data_r;
   logic [7:0]            data_nxt;
   logic                  last_r;
   logic                  last_nxt;

   always_comb
   begin
      cur_nxt  = cur_r;
      busy_nxt = busy_r;
      byte_nxt = byte_r;
      if (pop)
      begin
         cur_nxt  = q_r[0];
         busy_nxt = 1'b1;
         byte_nxt = 3'h0;
      end
      else if (busy_r && i_mbx_ready)
      begin
         byte_nxt = byte_r + 3'h1;
         if (byte_r == emr_pkg::EMR_LAST_BYTE)
         begin
            busy_nxt = 1'b0;
         end
      end
      data_nxt = cur_nxt[{byte_nxt, 3'h0} +: 8];
      last_nxt = busy_nxt & (byte_nxt == emr_pkg::EMR_LAST_BYTE);
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cnt_r  <= 4'h0;
         cur_r  <= '0;
         busy_r <= 1'b0;
         byte_r <= 3'h0;
         data_r <= 8'h00;
         last_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         cur_r  <= cur_nxt;
         busy_r <= busy_nxt;
         byte_r <= byte_nxt;
         data_r <= data_nxt;
         last_r <= last_nxt;
      end
   end

   //=======================================================================
   // Output stage.
   assign o_mbx_valid = busy_r;
   assign o_mbx_last  = last_r;
   assign o_mbx_data  = data_r;

endmodule : emr_reporter

// file: emr_reporter_checker.sv
// Port checker for the emergency message reporter.
//==========================================================
// Checker.
module emr_reporter_checker
(
   // Watched ports.
   input wire logic                i_clock,
   input wire logic                i_sys_rst,
   input wire logic                i_alarm,
   input wire logic                i_flags_wr,
   input wire logic [15:0]         i_flags_wdata,
   input wire logic                i_hist_clear_done,
   input wire emr_pkg::emr_state_t i_esm_state,
   input wire logic                i_mbx_ready,
   input wire logic [15:0]         o_flags,
   input wire logic                o_mbx_valid,
   input wire logic [7:0]          o_mbx_data,
   input wire logic                o_mbx_last
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   AST_FIXED: assert property (o_flags[4:1] == 4'hF)
      else $error("fixed bits wrong");
   AST_EN_ON: assert property (
      i_flags_wr && i_flags_wdata[0] |=> o_flags[0])
      else $error("enable not set");
   AST_EN_OFF: assert property (
      i_flags_wr && !i_flags_wdata[0] |=> !o_flags[0])
      else $error("enable not cleared");
   AST_HIST_SET: assert property (
      i_hist_clear_done && !i_alarm |=> o_flags[5])
      else $error("history bit not set");
   AST_HIST_CLR: assert property (
      $rose(i_alarm) && o_flags[0] |=> !o_flags[5])
      else $error("history bit not cleared");
   AST_HOLD: assert property (
      o_mbx_valid && !i_mbx_ready |=> o_mbx_valid && $stable(o_mbx_data))
      else $error("byte not held");
   AST_INIT_HOLD: assert property (
      i_esm_state == emr_pkg::EMR_INIT && !o_mbx_valid |=> !o_mbx_valid)
      else $error("sent in init");
   AST_GAP: assert property (
      o_mbx_valid && i_mbx_ready && o_mbx_last |=> !o_mbx_valid)
      else $error("no gap after message");
endmodule : emr_reporter_checker

// file: emr_mbx_sink.sv
// Mailbox sink model that gathers message bytes.
//==========================================================
// Sink.
module emr_mbx_sink
(
   // Stream and results.
   input  wire logic       i_clock,
   input  wire logic       i_slow,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   input  wire logic       i_last,
   output logic            o_ready = 1'h0,
   output logic            o_got = 1'h0,
   output logic [63:0]     o_msg,
   output logic [7:0]      o_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] n_r = 8'h00;
   always @(posedge i_clock)
   begin
      o_ready <= !i_slow || 1'($urandom);
      o_got <= 1'h0;
      if (i_valid && o_ready)
      begin
         o_msg[8 * n_r[2:0] +: 8] <= i_data;
         n_r <= i_last ? 8'h00 : n_r + 8'h01;
         o_n <= n_r + 8'h01;
         o_got <= i_last;
      end
   end
endmodule : emr_mbx_sink

// file: emr_reporter_tb_top.sv
// Testbench for the emergency message reporter.
//==========================================================
// Bench.
module emr_reporter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'h0, i_sys_rst = 1'h1, i_alarm = 1'h0, i_warning = 1'h0;
   logic i_hist_clear_done = 1'h0, i_flags_wr = 1'h0, slow = 1'h0;
   logic i_mbx_ready, o_mbx_valid, o_mbx_last, got;
   logic [15:0] i_err_code = 16'h0, i_flags_wdata = 16'h0, o_flags;
   logic [7:0]  i_err_reg = 8'h0, o_mbx_data, n;
   logic [39:0] i_vendor = 40'h0;
   logic [63:0] msg, exp_q[$];
   emr_pkg::emr_state_t i_esm_state = emr_pkg::EMR_OP;
   int n_mismatch = 0, check_count = 0;
   emr_reporter DUT (.*);
   emr_mbx_sink u_sink (.i_clock, .i_slow(slow), .i_valid(o_mbx_valid),
      .i_data(o_mbx_data), .i_last(o_mbx_last), .o_ready(i_mbx_ready),
      .o_got(got), .o_msg(msg), .o_n(n));
   always #12.5 i_clock = !i_clock;
   task automatic check(input logic ok);
      check_count++;
      if (ok !== 1'h1)
      begin
         n_mismatch++;
         $display("mismatch at %0t: wrong result", $time);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic tick(input int k);
      repeat (k) @(posedge i_clock);
   endtask : tick
   task automatic alarm(input logic q);
      i_err_code <= 16'($urandom);
      i_err_reg <= 8'($urandom);
      i_vendor <= {8'($urandom), 32'($urandom)};
      i_alarm <= 1'h1;
      tick(1);
      if (q) exp_q.push_back({i_vendor, i_err_reg, i_err_code});
      i_alarm <= 1'h0;
      tick(1);
   endtask : alarm
   task automatic set_en(input logic b);
      i_flags_wr <= 1'h1;
      i_flags_wdata <= {15'h0, b};
      tick(1);
      i_flags_wr <= 1'h0;
   endtask : set_en
   task automatic drain();
      for (int i = 0; exp_q.size() > 0; i++)
      begin
         tick(1);
         if (i > 3000) n_mismatch++;
         if (i > 3000) complete_run();
      end
      tick(4);
   endtask : drain
   always @(negedge i_clock)
      if (got === 1'h1)
      begin
         check(n === 8'h08);
         if (exp_q.size() == 0) check(1'h0);
         else check(msg === exp_q.pop_front());
      end
   initial
   begin
      void'($urandom(7520));
      tick(4);
      i_sys_rst <= 1'h0;
      check(o_flags === 16'h003F);
      for (int i = 0; i < 12; i++)
      begin
         slow <= i[0];
         alarm(1'h1);
         if (i[1]) drain();
      end
      drain();
      check(o_flags[5] === 1'h0);
      $display("test alarms done");
      i_warning <= 1'h1;
      tick(30);
      i_warning <= 1'h0;
      set_en(1'h0);
      alarm(1'h0);
      tick(30);
      check(o_flags[0] === 1'h0);
      i_hist_clear_done <= 1'h1;
      tick(1);
      i_hist_clear_done <= 1'h0;
      tick(1);
      check(o_flags[5] === 1'h1);
      set_en(1'h1);
      $display("test flags done");
      i_esm_state <= emr_pkg::EMR_INIT;
      for (int i = 0; i < 10; i++) alarm(i < 8);
      tick(30);
      check(exp_q.size() == 8);
      check(o_mbx_valid === 1'h0);
      i_esm_state <= emr_pkg::EMR_PREOP;
      drain();
      $display("test init queue done");
      complete_run();
   end
endmodule : emr_reporter_tb_top
bind emr_reporter emr_reporter_checker u_chk (.*);
